// *** design/par_pkg.sv ***
/*
 * Constants, types and register map of the private address resolver.
 * Assumes a single 100 MHz system clock and a word-wide memory master port.
 */
package par_pkg;
   // Register offsets (byte addresses)
   localparam logic [11:0] OFS_START     = 12'h000;
   localparam logic [11:0] OFS_STOP      = 12'h008;
   localparam logic [11:0] OFS_EV_DONE   = 12'h100;
   localparam logic [11:0] OFS_EV_MATCH  = 12'h104;
   localparam logic [11:0] OFS_EV_NOMAT  = 12'h108;
   localparam logic [11:0] OFS_IRQ_SET   = 12'h304;
   localparam logic [11:0] OFS_IRQ_CLR   = 12'h308;
   localparam logic [11:0] OFS_LAST_KEY  = 12'h400;
   localparam logic [11:0] OFS_ENABLE    = 12'h500;
   localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
   localparam logic [11:0] OFS_KEY_PTR   = 12'h508;
   localparam logic [11:0] OFS_ADDR_PTR  = 12'h510;
   localparam logic [11:0] OFS_SCR_PTR   = 12'h514;
   // Field layout and reset values
   localparam int          BIT_DONE      = 0;
   localparam int          BIT_MATCH     = 1;
   localparam int          BIT_NOMAT     = 2;
   localparam logic [1:0]  ENABLE_ON     = 2'h3;
   localparam logic [1:0]  ENABLE_OFF    = 2'h0;
   localparam logic [4:0]  KEY_COUNT_RST = 5'h01;
   localparam logic [4:0]  KEY_COUNT_MAX = 5'h10;
   localparam logic [31:0] PTR_RST       = 32'h0000_0000;
   // Key list geometry
   localparam logic [31:0] KEY_STRIDE    = 32'h0000_0010;
   localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
   localparam logic [1:0]  KEY_LAST_WORD = 2'h3;
   // Timing: fixed overhead plus a per-key slot
   localparam int          CLK_NS        = 10;
   localparam int          OVH_NS        = 1000;
   localparam int          KEY_NS        = 5875;
   localparam logic [9:0]  OVH_CYC       = 10'(OVH_NS / CLK_NS);
   localparam logic [9:0]  KEY_CYC       = 10'(KEY_NS / CLK_NS);
   localparam logic [9:0]  ONE_CYC       = 10'h001;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_OVH, ST_ADDR0, ST_ADDR1, ST_KEY, ST_HASH, ST_SCR, ST_SLOT
   } par_state_type;

   // Memory master request
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } par_mem_req_type;

   // Memory master response
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } par_mem_rsp_type;
endpackage : par_pkg

// *** design/par_resolver.sv ***
/*
 * Private address resolver: walks a list of identity keys in RAM, hashes the
 * random part of a six-byte address with each key and compares the result.
 * Assumes an external hash engine on the same clock and a RAM master port
 * that answers each request with a one-cycle ack, read data beside it.
 */
// Summary of operation
// - A write of 1 to start launches resolution and a write of 1 to stop halts it.
// - Done, match and no-match event registers read 1 after their event and are writable.
// - Writing 1 to bits 0..2 of the set register enables that event's interrupt; reads show enables.
// - Writing 1 to bits 0..2 of the clear register disables that interrupt; 0 does nothing.
// - A read-only status field holds the index of the key that last produced a match.
// - A two-bit enable field turns the resolver on with 3 and off with 0, off after reset.
// - A five-bit key count, legal 1 to 16, resets to 1.
// - A 32-bit pointer gives the RAM start of the key list.
// - A 32-bit pointer gives the RAM address of the six-byte address.
// - Resolution takes a fixed 1 us plus a constant slot per key tried.
// - Eight keys take typically 48 us when the resolver has RAM priority.
// - Keys are tried from key 0; match on the first hit, no-match after all fail.
// - The resolver stops on a match or after the counted keys, then raises done.
// - Key n sits at byte offset 16 times n from the list pointer, 16 bytes long.
// - All RAM accesses are over when done, match or no-match is raised.
`timescale 1ns/10ps
module par_resolver (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   // Register port
   input  wire logic [11:0]              reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [31:0]              reg_rdata,
   // RAM master
   output par_pkg::par_mem_req_type      mem_req,
   input  wire par_pkg::par_mem_rsp_type mem_rsp,
   // Hash engine
   output logic                          hash_start,
   output logic      [127:0]             hash_key,
   output logic      [23:0]              hash_prand,
   input  wire logic                     hash_done,
   input  wire logic [23:0]              hash_value,
   // Interrupt
   output logic                          irq
);
   // Effective key count, clamped into the legal range
   function automatic logic [4:0] eff_count(input logic [4:0] n);
      eff_count = (n == 5'h00) ? 5'h01 : (n > par_pkg::KEY_COUNT_MAX) ? par_pkg::KEY_COUNT_MAX : n;
   endfunction : eff_count

   // Register address decode, for writes and reads
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   par_pkg::par_state_type  state_r, state_nxt;
   logic [2:0]              ev_r;
   logic [2:0]              ien_r;
   logic [3:0]              last_key_r;
   logic [1:0]              enable_r;
   logic [4:0]              key_count_r;
   logic [31:0]             key_ptr_r, addr_ptr_r, scr_ptr_r;
   logic [31:0]             rdata_r;
   logic [47:0]             addr_buf_r;
   logic [127:0]            key_buf_r;
   logic [3:0]              key_idx_r;
   logic [1:0]              word_r;
   logic [9:0]              tmr_r;
   logic [23:0]             hash_r;
   logic                    stop_pend_r;
   logic                    hash_first_r;
   par_pkg::par_mem_req_type req_r;

   // Write decode
   wire wr_start  = reg_wr && hit(reg_addr, par_pkg::OFS_START) && reg_wdata[0];
   wire wr_stop   = reg_wr && hit(reg_addr, par_pkg::OFS_STOP) && reg_wdata[0];
   wire wr_ev_d   = reg_wr && hit(reg_addr, par_pkg::OFS_EV_DONE);
   wire wr_ev_m   = reg_wr && hit(reg_addr, par_pkg::OFS_EV_MATCH);
   wire wr_ev_n   = reg_wr && hit(reg_addr, par_pkg::OFS_EV_NOMAT);
   wire wr_iset   = reg_wr && hit(reg_addr, par_pkg::OFS_IRQ_SET);
   wire wr_iclr   = reg_wr && hit(reg_addr, par_pkg::OFS_IRQ_CLR);
   wire wr_enable = reg_wr && hit(reg_addr, par_pkg::OFS_ENABLE);
   wire wr_count  = reg_wr && hit(reg_addr, par_pkg::OFS_KEY_COUNT);
   wire wr_kptr   = reg_wr && hit(reg_addr, par_pkg::OFS_KEY_PTR);
   wire wr_aptr   = reg_wr && hit(reg_addr, par_pkg::OFS_ADDR_PTR);
   wire wr_sptr   = reg_wr && hit(reg_addr, par_pkg::OFS_SCR_PTR);
   wire [2:0] wr_bits = reg_wdata[2:0]; // Enable bits of a set or clear write

   // Status and control
   wire       is_on      = (enable_r == par_pkg::ENABLE_ON);
   wire       busy       = (state_r != par_pkg::ST_IDLE);
   wire       mem_ack    = req_r.req && mem_rsp.ack;
   wire       mem_idle   = !req_r.req;
   wire [4:0] count_eff  = eff_count(key_count_r);
   wire       last_key   = ({1'b0, key_idx_r} == count_eff - 5'h01);
   wire       abort      = (stop_pend_r || wr_stop || !is_on) && mem_idle;
   wire       slot_end   = (tmr_r >= par_pkg::KEY_CYC - par_pkg::ONE_CYC);
   wire       is_match   = (hash_r == addr_buf_r[23:0]);
   wire       finish     = (state_r == par_pkg::ST_SLOT) && slot_end && !abort;
   wire       ev_match   = finish && is_match;
   wire       ev_nomat   = finish && !is_match && last_key;
   wire       ev_done    = ev_match || ev_nomat;
   wire [31:0] key_addr  = key_ptr_r + par_pkg::KEY_STRIDE * {28'h0, key_idx_r}
                           + par_pkg::WORD_BYTES * {30'h0, word_r};

   // Read mux
   wire [31:0] rd_mux =
      hit(reg_addr, par_pkg::OFS_EV_DONE)   ? {31'h0, ev_r[par_pkg::BIT_DONE]}  :
      hit(reg_addr, par_pkg::OFS_EV_MATCH)  ? {31'h0, ev_r[par_pkg::BIT_MATCH]} :
      hit(reg_addr, par_pkg::OFS_EV_NOMAT)  ? {31'h0, ev_r[par_pkg::BIT_NOMAT]} :
      hit(reg_addr, par_pkg::OFS_IRQ_SET)   ? {29'h0, ien_r}                    :
      hit(reg_addr, par_pkg::OFS_IRQ_CLR)   ? {29'h0, ien_r}                    :
      hit(reg_addr, par_pkg::OFS_LAST_KEY)  ? {28'h0, last_key_r}               :
      hit(reg_addr, par_pkg::OFS_ENABLE)    ? {30'h0, enable_r}                 :
      hit(reg_addr, par_pkg::OFS_KEY_COUNT) ? {27'h0, key_count_r}              :
      hit(reg_addr, par_pkg::OFS_KEY_PTR)   ? key_ptr_r                         :
      hit(reg_addr, par_pkg::OFS_ADDR_PTR)  ? addr_ptr_r                        :
      hit(reg_addr, par_pkg::OFS_SCR_PTR)   ? scr_ptr_r                         : 32'h0000_0000;

   // Outputs
   assign reg_rdata  = rdata_r;
   assign mem_req    = req_r;
   assign hash_key   = key_buf_r;
   assign hash_prand = addr_buf_r[47:24];
   assign hash_start = (state_r == par_pkg::ST_HASH) && hash_first_r && !abort;
   assign irq        = |(ev_r & ien_r);

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         par_pkg::ST_IDLE:  if (wr_start && is_on) state_nxt = par_pkg::ST_OVH;
         par_pkg::ST_OVH:   if (tmr_r == par_pkg::OVH_CYC - par_pkg::ONE_CYC)
                               state_nxt = par_pkg::ST_ADDR0;
         par_pkg::ST_ADDR0: if (mem_ack) state_nxt = par_pkg::ST_ADDR1;
         par_pkg::ST_ADDR1: if (mem_ack) state_nxt = par_pkg::ST_KEY;
         par_pkg::ST_KEY:   if (mem_ack && word_r == par_pkg::KEY_LAST_WORD)
                               state_nxt = par_pkg::ST_HASH;
         par_pkg::ST_HASH:  if (hash_done) state_nxt = par_pkg::ST_SCR;
         par_pkg::ST_SCR:   if (mem_ack) state_nxt = par_pkg::ST_SLOT;
         par_pkg::ST_SLOT:  if (slot_end)
                               state_nxt = (is_match || last_key) ? par_pkg::ST_IDLE
                                                                   : par_pkg::ST_KEY;
         default:           state_nxt = par_pkg::ST_IDLE;
      endcase
      if (busy && abort) state_nxt = par_pkg::ST_IDLE;
   end

   // State, stop latch and slot timer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r     <= par_pkg::ST_IDLE;
         stop_pend_r <= 1'b0;
         tmr_r       <= 10'h000;
         hash_first_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         // The slot timer runs on through the hash state, so mark its first cycle here
         hash_first_r <= (state_nxt == par_pkg::ST_HASH) && (state_r != par_pkg::ST_HASH);
         stop_pend_r <= busy && !abort && (stop_pend_r || wr_stop);
         if (state_r == par_pkg::ST_IDLE || state_nxt == par_pkg::ST_ADDR0 ||
             (state_r == par_pkg::ST_SLOT && state_nxt == par_pkg::ST_KEY))
            tmr_r <= 10'h000;
         else if (tmr_r != 10'h3FF)
            tmr_r <= tmr_r + 10'h001;
      end
   end

   // RAM master: one request at a time, held until ack
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_r  <= '0;
         word_r <= 2'h0;
      end else if (mem_ack || !busy || abort) begin
         req_r  <= '0;
         if (state_r == par_pkg::ST_KEY && mem_ack)
            word_r <= word_r + 2'h1;
         else if (!busy)
            word_r <= 2'h0; // A stopped run must not leave a half-read key behind
      end else if (!req_r.req) begin
         case (state_r)
            par_pkg::ST_ADDR0: req_r <= '{1'b1, 1'b0, addr_ptr_r, 32'h0};
            par_pkg::ST_ADDR1: req_r <= '{1'b1, 1'b0, addr_ptr_r + par_pkg::WORD_BYTES, 32'h0};
            par_pkg::ST_KEY:   req_r <= '{1'b1, 1'b0, key_addr, 32'h0};
            par_pkg::ST_SCR:   req_r <= '{1'b1, 1'b1, scr_ptr_r, {8'h00, hash_r}};
            default:           req_r <= '0;
         endcase
      end
   end

   // Capture of address, key words and hash result
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addr_buf_r <= 48'h0;
         key_buf_r  <= 128'h0;
         hash_r     <= 24'h0;
      end else begin
         if (mem_ack && state_r == par_pkg::ST_ADDR0) addr_buf_r[31:0]  <= mem_rsp.rdata;
         if (mem_ack && state_r == par_pkg::ST_ADDR1) addr_buf_r[47:32] <= mem_rsp.rdata[15:0];
         if (mem_ack && state_r == par_pkg::ST_KEY)
            key_buf_r[32*word_r +: 32] <= mem_rsp.rdata;
         if (hash_done && state_r == par_pkg::ST_HASH) hash_r <= hash_value;
      end
   end

   // Key index walks from key zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         key_idx_r  <= 4'h0;
         last_key_r <= 4'h0;
      end else begin
         if (state_r == par_pkg::ST_IDLE) key_idx_r <= 4'h0;
         else if (state_r == par_pkg::ST_SLOT && state_nxt == par_pkg::ST_KEY)
            key_idx_r <= key_idx_r + 4'h1;
         if (ev_match) last_key_r <= key_idx_r;
      end
   end

   // Events: hardware set wins over a software write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ev_r <= 3'h0;
      end else begin
         ev_r[par_pkg::BIT_DONE]  <= ev_done  || (wr_ev_d ? reg_wdata[0] : ev_r[par_pkg::BIT_DONE]);
         ev_r[par_pkg::BIT_MATCH] <= ev_match || (wr_ev_m ? reg_wdata[0] : ev_r[par_pkg::BIT_MATCH]);
         ev_r[par_pkg::BIT_NOMAT] <= ev_nomat || (wr_ev_n ? reg_wdata[0] : ev_r[par_pkg::BIT_NOMAT]);
      end
   end

   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ien_r       <= 3'h0;
         enable_r    <= par_pkg::ENABLE_OFF;
         key_count_r <= par_pkg::KEY_COUNT_RST;
         key_ptr_r   <= par_pkg::PTR_RST;
         addr_ptr_r  <= par_pkg::PTR_RST;
         scr_ptr_r   <= par_pkg::PTR_RST;
      end else begin
         if (wr_iset) ien_r <= ien_r | reg_wdata[2:0];
         if (wr_iclr) ien_r <= ien_r & ~reg_wdata[2:0];
         if (wr_enable) enable_r <= reg_wdata[1:0];
         if (wr_count) key_count_r <= reg_wdata[4:0];
         if (wr_kptr) key_ptr_r <= reg_wdata;
         if (wr_aptr) addr_ptr_r <= reg_wdata;
         if (wr_sptr) scr_ptr_r <= reg_wdata;
      end
   end

   // Read data, valid the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) rdata_r <= 32'h0;
      else if (reg_rd) rdata_r <= rd_mux;
      else rdata_r <= 32'h0;
   end

   // Checks
   property p_start;
      @(posedge clk_sys) disable iff (rst)
      (!busy && wr_start && is_on) |=> (state_r == par_pkg::ST_OVH);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_start_off;
      @(posedge clk_sys) disable iff (rst)
      (!busy && !is_on) |=> !busy;
   endproperty
   a_start_off: assert property (p_start_off) else $error("start taken while off");

   property p_ovh;
      @(posedge clk_sys) disable iff (rst)
      (state_r == par_pkg::ST_OVH && state_nxt == par_pkg::ST_ADDR0)
         |-> (tmr_r == par_pkg::OVH_CYC - par_pkg::ONE_CYC);
   endproperty
   a_ovh: assert property (p_ovh) else $error("overhead wait length wrong");

   property p_slot;
      @(posedge clk_sys) disable iff (rst)
      ev_done |-> (tmr_r >= par_pkg::KEY_CYC - par_pkg::ONE_CYC);
   endproperty
   a_slot: assert property (p_slot) else $error("key slot cut short");

   property p_done;
      @(posedge clk_sys) disable iff (rst)
      (ev_match || ev_nomat) |=> ev_r[par_pkg::BIT_DONE] && !busy;
   endproperty
   a_done: assert property (p_done) else $error("done not raised at stop");

   property p_idx;
      @(posedge clk_sys) disable iff (rst)
      ev_match |=> (last_key_r == $past(key_idx_r));
   endproperty
   a_idx: assert property (p_idx) else $error("last key index wrong");

   property p_order;
      @(posedge clk_sys) disable iff (rst)
      (state_r == par_pkg::ST_SLOT && state_nxt == par_pkg::ST_KEY)
         |=> (state_r == par_pkg::ST_KEY) && (key_idx_r == $past(key_idx_r) + 4'h1);
   endproperty
   a_order: assert property (p_order) else $error("keys not tried in order");

   property p_quiet;
      @(posedge clk_sys) disable iff (rst)
      ev_done |-> !req_r.req;
   endproperty
   a_quiet: assert property (p_quiet) else $error("RAM busy at event");

   property p_keyaddr;
      @(posedge clk_sys) disable iff (rst)
      (req_r.req && state_r == par_pkg::ST_KEY)
         |-> (req_r.addr == key_ptr_r + par_pkg::KEY_STRIDE * {28'h0, key_idx_r}
                            + par_pkg::WORD_BYTES * {30'h0, word_r});
   endproperty
   a_keyaddr: assert property (p_keyaddr) else $error("key address wrong");

   property p_iset;
      @(posedge clk_sys) disable iff (rst)
      (wr_iset && !wr_iclr) |=> ((ien_r & $past(wr_bits)) == $past(wr_bits));
   endproperty
   a_iset: assert property (p_iset) else $error("enable set failed");

   property p_iclr;
      @(posedge clk_sys) disable iff (rst)
      wr_iclr |=> ((ien_r & $past(wr_bits)) == 3'h0);
   endproperty
   a_iclr: assert property (p_iclr) else $error("enable clear failed");

   property p_stop;
      @(posedge clk_sys) disable iff (rst)
      (busy && wr_stop && mem_idle) |=> !busy && (ev_r == $past(ev_r));
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not halt");

   // Start request on an idle, enabled resolver
   sequence s_go;
      !busy && wr_start && is_on;
   endsequence

   // Address fetch of a run, still on key zero
   sequence s_fetch;
      (state_r == par_pkg::ST_ADDR0) && (key_idx_r == 4'h0);
   endsequence

   // One microsecond of overhead, then the first fetch; stop or enable writes cancel it
   property p_first_key;
      @(posedge clk_sys) disable iff (rst || wr_stop || wr_enable)
      s_go |-> ##101 s_fetch;
   endproperty
   a_first_key: assert property (p_first_key) else $error("overhead or first key wrong");

   // Last key word taken with no stop pending
   sequence s_key_done;
      (state_r == par_pkg::ST_KEY) && mem_ack && (word_r == par_pkg::KEY_LAST_WORD)
         && !stop_pend_r;
   endsequence

   // A single start pulse to the hash engine
   sequence s_hash_pulse;
      hash_start ##1 !hash_start;
   endsequence

   property p_hash;
      @(posedge clk_sys) disable iff (rst || wr_stop || wr_enable)
      s_key_done |=> s_hash_pulse;
   endproperty
   a_hash: assert property (p_hash) else $error("hash not started once per key");

   // No RAM request may stand while the resolver is idle
   property p_quiet_idle;
      @(posedge clk_sys) disable iff (rst)
      !busy |-> !req_r.req;
   endproperty
   a_quiet_idle: assert property (p_quiet_idle) else $error("RAM request while idle");
endmodule : par_resolver

// *** sim/par_far_model.sv ***
/*
 * Far-side model of the resolver: a word RAM with settable wait states and a
 * toy hash engine (low 24 key bits XOR the random part).
 * Assumes the resolver's clock and reset and the request/ack port of par_pkg.
 */
`timescale 1ns/10ps
module par_far_model (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   // RAM port
   input  wire par_pkg::par_mem_req_type mem_req,
   output par_pkg::par_mem_rsp_type      mem_rsp,
   input  wire logic [3:0]               lat,
   // Hash engine port
   input  wire logic                     hash_start,
   input  wire logic [127:0]             hash_key,
   input  wire logic [23:0]              hash_prand,
   output logic                          hash_done,
   output logic      [23:0]              hash_value
);
   logic [31:0] mem [0:255];
   logic [3:0]  wait_r;
   logic [2:0]  hcnt_r;
   int          nacc;

   // RAM: ack after lat wait states; read bus scrambled outside an ack
   // Plain always, since the bench preloads the array from outside
   always @(posedge clk_sys) begin
      if (rst) begin
         mem_rsp <= '0;
         wait_r  <= '0;
         nacc    <= 0;
      end else if (mem_req.req && !mem_rsp.ack && wait_r == lat) begin
         mem_rsp.ack   <= 1'b1;
         mem_rsp.rdata <= mem[mem_req.addr[9:2]];
         if (mem_req.we)
            mem[mem_req.addr[9:2]] <= mem_req.wdata;
         wait_r <= '0;
         nacc   <= nacc + 1;
      end else begin
         mem_rsp.ack   <= 1'b0;
         mem_rsp.rdata <= ~mem_rsp.rdata;
         wait_r        <= (mem_req.req && !mem_rsp.ack) ? wait_r + 4'h1 : 4'h0;
      end
   end

   // Hash engine: answers four cycles after a start pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hcnt_r     <= '0;
         hash_done  <= 1'b0;
         hash_value <= '0;
      end else begin
         hcnt_r     <= hash_start ? 3'h3 : (hcnt_r != 3'h0 ? hcnt_r - 3'h1 : 3'h0);
         hash_done  <= (hcnt_r == 3'h1);
         hash_value <= (hcnt_r == 3'h1) ? hash_key[23:0] ^ hash_prand : ~hash_value;
      end
   end
endmodule : par_far_model

// *** sim/tb_top.sv ***
/*
 * Self-checking bench of the resolver: register access, runs that match on key
 * 0 of one key and on the last of eight and of sixteen keys, a miss, abort by stop, start while disabled.
 * Assumes par_far_model as RAM and hash engine; key list at 0x100.
 */
`timescale 1ns/10ps
module tb_top;
   localparam logic [23:0] HASH  = 24'h3C5A96;
   localparam logic [23:0] PRAND = 24'h4B2E71;
   logic                    clk_sys = 1'b0;
   logic                    rst = 1'b1;
   logic [11:0]             reg_addr = 12'h000;
   logic [31:0]             reg_wdata = 32'h0;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic [31:0]             reg_rdata;
   par_pkg::par_mem_req_type mem_req;
   par_pkg::par_mem_rsp_type mem_rsp;
   logic                    hash_start;
   logic [127:0]            hash_key;
   logic [23:0]             hash_prand;
   logic                    hash_done;
   logic [23:0]             hash_value;
   logic                    irq;
   logic [3:0]              lat = 4'h0;
   logic [31:0]             rv;
   logic [3:0]              lastk = 4'h0;
   int                      miscompares = 0;
   int                      num_checks = 0;
   int                      n0;
   logic [11:0]             ofs [12] = '{12'h100, 12'h104, 12'h108, 12'h304, 12'h308,
      12'h400, 12'h500, 12'h504, 12'h508, 12'h510, 12'h514, 12'h200};
   logic [31:0]             rval [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0};

   par_resolver dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_req(mem_req), .mem_rsp(mem_rsp), .hash_start(hash_start), .hash_key(hash_key),
      .hash_prand(hash_prand), .hash_done(hash_done), .hash_value(hash_value), .irq(irq));
   par_far_model ram (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .lat(lat), .hash_start(hash_start), .hash_key(hash_key), .hash_prand(hash_prand),
      .hash_done(hash_done), .hash_value(hash_value));

   // Clock
   always #5 clk_sys = ~clk_sys;

   // Bus write: one strobe cycle, then one idle cycle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   // Bus read: data taken in the cycle after the strobe only
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask : rchk

   // One run over n keys, key j resolves (j >= n: none does)
   task automatic run(input int n, input int j, input logic [3:0] l);
      int c;
      int t;
      c = 0;
      t = (j < n) ? j + 1 : n;
      for (int k = 0; k < 64; k++)
         ram.mem[64 + k] = 32'(k * 32'h01010101);
      for (int k = 0; k < 16; k++)
         ram.mem[64 + 4 * k] = {8'hA5, HASH ^ PRAND ^ ((k == j) ? 24'h0 : 24'(k + 1))};
      ram.mem[16] = {PRAND[7:0], HASH};
      ram.mem[17] = {16'hFFFF, PRAND[23:8]};
      lat <= l;
      wr(12'h504, 32'(n));
      for (int e = 0; e < 3; e++)
         wr(12'h100 + 12'(4 * e), 32'h0);
      wr(12'h000, 32'h1);
      do begin
         @(posedge clk_sys);
         c++;
      end while (irq !== 1'b1 && c < 12000);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, mem_req.req}, 32'h0);
      chk(ram.mem[32], {8'h00, HASH ^ ((j < n) ? 24'h0 : 24'(n))});
      if (l == 4'h0)
         chk(32'(c >= 98 + 587 * t && c <= 140 + 587 * t), 32'h1);
      rchk(12'h104, 32'(j < n));
      rchk(12'h108, 32'(j >= n));
      rchk(12'h100, 32'h1);
      if (j < n)
         lastk = 4'(j);
      rchk(12'h400, {28'h0, lastk});
   endtask : run

   // Verdict and end of run
   task automatic results();
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #400000;
      miscompares++;
      results();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      foreach (ofs[i]) rchk(ofs[i], rval[i]);
      wr(12'h508, 32'h100);
      rchk(12'h508, 32'h100);
      wr(12'h510, 32'h40);
      rchk(12'h510, 32'h40);
      wr(12'h514, 32'h80);
      rchk(12'h514, 32'h80);
      wr(12'h504, 32'h10);
      rchk(12'h504, 32'h10);
      wr(12'h000, 32'h1);
      repeat (300) @(posedge clk_sys);
      chk(32'(ram.nacc), 32'h0);
      rchk(12'h100, 32'h0);
      wr(12'h500, 32'h3);
      rchk(12'h500, 32'h3);
      wr(12'h304, 32'h7);
      rchk(12'h304, 32'h7);
      wr(12'h308, 32'h6);
      rchk(12'h308, 32'h1);
      wr(12'h308, 32'h0);
      rchk(12'h304, 32'h1);
      run(1, 0, 4'h0);
      run(8, 7, 4'h0);
      run(16, 15, 4'h0);
      run(3, 16, 4'h5);
      wr(12'h308, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(12'h304, 32'h4);
      chk({31'h0, irq}, 32'h1);
      wr(12'h108, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(12'h100, 32'h0);
      wr(12'h504, 32'h10);
      wr(12'h000, 32'h1);
      repeat (1000) @(posedge clk_sys);
      wr(12'h008, 32'h1);
      repeat (800) @(posedge clk_sys);
      n0 = ram.nacc;
      repeat (100) @(posedge clk_sys);
      chk(32'(ram.nacc), 32'(n0));
      rchk(12'h100, 32'h0);
      rchk(12'h104, 32'h0);
      rchk(12'h108, 32'h0);
      wr(12'h500, 32'h0);
      rchk(12'h500, 32'h0);
      wr(12'h000, 32'h1);
      repeat (200) @(posedge clk_sys);
      chk(32'(ram.nacc), 32'(n0));
      results();
   end
endmodule : tb_top
